// ---- dtc_pkg.sv ----
// Purpose: constants for the dual timer/counter block
// Assumes: APB byte address is four times the register index
// Notes: machine cycle is two core clocks
// Contract
// - timer function adds one per machine cycle while enabled
// - counter function adds one per falling edge on the count pin
// - count pin sampled once per machine cycle, high then low counts
// - new count appears in the machine cycle after the detected edge
// - at most one counted edge per four core clocks
// - source select bit 2 / bit 6: clear internal, set count pin
// - gate bit 3 / bit 7: run needs gate pin high when set
// - mode is aux bit plus two mode bits per timer
// - code 000 uses low byte as 5-bit prescaler
// - code 001 cascades both bytes into a 16-bit counter
// - code 010 reloads low byte from high byte on overflow
// - code 011 timer zero low byte uses timer zero controls
// - code 011 timer zero high byte counts machine cycles with timer one run and flag
// - timer one in code 011 stops and holds its count
// - optional toggle of the timer pin on every overflow
// - run bits control bit 4 and 6; hardware sets overflow flag
// - code 000 is 13 bits and flags rollover to zero
// - code 110 is PWM, 256 machine cycles, high byte sets low time
// - toggle pin starts high, works only with internal clocking
package dtc_pkg;
    localparam logic [7:0] IDX_CTRL    = 8'h88;
    localparam logic [7:0] IDX_MODE    = 8'h89;
    localparam logic [7:0] IDX_AUX     = 8'h8f;
    localparam logic [7:0] IDX_LOW0    = 8'h90;
    localparam logic [7:0] IDX_HIGH0   = 8'h91;
    localparam logic [7:0] IDX_LOW1    = 8'h92;
    localparam logic [7:0] IDX_HIGH1   = 8'h93;
    localparam logic [7:0] IDX_TOGGLE  = 8'h94;
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam int         MODE_STRIDE = 4;
    localparam int         MODE_M0     = 0;
    localparam int         MODE_M1     = 1;
    localparam int         MODE_SEL    = 2;
    localparam int         MODE_GATE   = 3;
    localparam int         AUX_M2_0    = 0;
    localparam int         AUX_M2_1    = 4;
    localparam int         CTRL_RUN0   = 4;
    localparam int         CTRL_FLAG0  = 5;
    localparam int         CTRL_RUN1   = 6;
    localparam int         CTRL_FLAG1  = 7;
    localparam logic [2:0] CODE_PRESC  = 3'h0;
    localparam logic [2:0] CODE_WIDE   = 3'h1;
    localparam logic [2:0] CODE_RELOAD = 3'h2;
    localparam logic [2:0] CODE_SPLIT  = 3'h3;
    localparam logic [2:0] CODE_PWM    = 3'h6;
    localparam logic [4:0] PRESC_TOP   = 5'h1f;
    localparam logic [7:0] BYTE_TOP    = 8'hff;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
endpackage

// ---- dtc_timer.sv ----
// Purpose: two 8/16-bit timer/counters behind an APB slave
// Assumes: clk is the core clock; pins synchronous to clk
// Notes: unmapped addresses answer with pslverr, read zero
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module dtc_timer
    import dtc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        gatePinZero,
    input  wire logic        gatePinOne,
    input  wire logic        countPinZeroIn,
    input  wire logic        countPinOneIn,
    output logic             countPinZeroOut,
    output logic             countPinZeroOe,
    output logic             countPinOneOut,
    output logic             countPinOneOe
);
    typedef struct packed {
        logic [7:0]      mode;
        logic [1:0]      modeHigh;
        logic [1:0]      run;
        logic [1:0]      flag;
        logic [1:0]      toggleEn;
        logic [1:0][7:0] low;
        logic [1:0][7:0] high;
        logic            phase;
        logic [1:0]      sample;
        logic [1:0]      edgePend;
        logic [1:0]      toggleOut;
        logic [1:0]      pinOut;
        logic [1:0]      pinOe;
        logic [31:0]     rdata;
    } dtc_state_t;

    dtc_state_t st;
    dtc_state_t next_st;

    logic       setup;
    logic       access;
    logic       hit;
    logic [7:0] idx;
    logic [1:0] gatePin;
    logic [1:0] countPin;

    assign setup    = psel & ~penable;
    assign access   = psel & penable;
    assign idx      = paddr[9:2];
    assign hit      = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                      (idx == IDX_CTRL || idx == IDX_MODE || idx == IDX_AUX ||
                       idx == IDX_LOW0 || idx == IDX_HIGH0 || idx == IDX_LOW1 ||
                       idx == IDX_HIGH1 || idx == IDX_TOGGLE);
    assign pready   = 1'b1;
    assign pslverr  = access & ~hit;
    assign prdata   = st.rdata;
    assign gatePin  = {gatePinOne, gatePinZero};
    assign countPin = {countPinOneIn, countPinZeroIn};
    assign countPinZeroOut = st.pinOut[0];
    assign countPinZeroOe  = st.pinOe[0];
    assign countPinOneOut  = st.pinOut[1];
    assign countPinOneOe   = st.pinOe[1];

    // one counting step for codes shared by both timers; {ovf, high, low}
    function automatic logic [16:0] step(
        input logic [2:0] code,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [16:0] r;
        r = {1'b0, hi, lo};
        unique case (code)
            CODE_PRESC:
            begin
                r[4:0] = lo[4:0] + 5'h1;
                if (lo[4:0] == PRESC_TOP)
                begin
                    r[15:8] = hi + 8'h1;
                    r[16]   = (hi == BYTE_TOP);
                end
            end
            CODE_WIDE:
            begin
                r[15:0] = {hi, lo} + 16'h1;
                r[16]   = ({hi, lo} == 16'hffff);
            end
            CODE_RELOAD:
            begin
                r[7:0] = (lo == BYTE_TOP) ? hi : lo + 8'h1;
                r[16]  = (lo == BYTE_TOP);
            end
            CODE_PWM:
            begin
                r[7:0] = lo + 8'h1;
                r[16]  = (lo == BYTE_TOP);
            end
            default:
            begin
                r = {1'b0, hi, lo};
            end
        endcase
        return r;
    endfunction

    always_comb
    begin
        logic        tick;
        logic        wr;
        logic [1:0]  ovf;
        logic [1:0]  inc;
        logic [2:0]  code [2];
        logic [16:0] res;
        logic        split;
        tick    = st.phase;
        wr      = access & pwrite & hit;
        ovf     = 2'b00;
        inc     = 2'b00;
        res     = 17'h0;
        split   = 1'b0;
        code    = '{default: 3'h0};
        next_st = st;
        next_st.phase = ~st.phase;
        for (int n = 0; n < 2; n++)
        begin
            code[n] = {st.modeHigh[n],
                       st.mode[n*MODE_STRIDE+MODE_M1],
                       st.mode[n*MODE_STRIDE+MODE_M0]};
        end
        split = (code[0] == CODE_SPLIT);

        // machine-cycle sampling; the edge is counted one tick later
        if (tick)
        begin
            next_st.sample   = countPin;
            next_st.edgePend = st.sample & ~countPin;
        end

        for (int n = 0; n < 2; n++)
        begin
            inc[n] = tick && st.run[n] &&
                     (!st.mode[n*MODE_STRIDE+MODE_GATE] || gatePin[n]) &&
                     (st.mode[n*MODE_STRIDE+MODE_SEL] ? st.edgePend[n]
                                                       : 1'b1);
        end

        // timer zero
        if (split)
        begin
            if (inc[0])
            begin
                next_st.low[0] = st.low[0] + 8'h1;
                ovf[0]         = (st.low[0] == BYTE_TOP);
            end
            if (tick && st.run[1])
            begin
                next_st.high[0] = st.high[0] + 8'h1;
                ovf[1]          = (st.high[0] == BYTE_TOP);
            end
        end
        else if (inc[0])
        begin
            res             = step(code[0], st.low[0], st.high[0]);
            next_st.low[0]  = res[7:0];
            next_st.high[0] = res[15:8];
            ovf[0]          = res[16];
        end

        // timer one; its flag belongs to timer zero high byte in split mode
        if (inc[1] && code[1] != CODE_SPLIT)
        begin
            res             = step(code[1], st.low[1], st.high[1]);
            next_st.low[1]  = res[7:0];
            next_st.high[1] = res[15:8];
            if (!split)
            begin
                ovf[1] = res[16];
            end
        end

        // software writes; run bit writes leave the count alone
        if (wr)
        begin
            unique case (idx)
                IDX_CTRL:
                begin
                    next_st.run  = {pwdata[CTRL_RUN1], pwdata[CTRL_RUN0]};
                    next_st.flag = {pwdata[CTRL_FLAG1], pwdata[CTRL_FLAG0]};
                end
                IDX_MODE:   next_st.mode     = pwdata[7:0];
                IDX_AUX:    next_st.modeHigh = {pwdata[AUX_M2_1], pwdata[AUX_M2_0]};
                IDX_LOW0:   next_st.low[0]   = pwdata[7:0];
                IDX_HIGH0:  next_st.high[0]  = pwdata[7:0];
                IDX_LOW1:   next_st.low[1]   = pwdata[7:0];
                IDX_HIGH1:  next_st.high[1]  = pwdata[7:0];
                IDX_TOGGLE: next_st.toggleEn = pwdata[1:0];
                default:    next_st.toggleEn = st.toggleEn;
            endcase
        end

        for (int n = 0; n < 2; n++)
        begin
            // overflow set wins over a software clear in the same cycle
            if (ovf[n])
            begin
                next_st.flag[n] = 1'b1;
            end
            if (code[n] == CODE_PWM && !(n == 1 && split))
            begin
                // level is hardware owned: 00 forces high, ff forces low
                if (st.high[n] == BYTE_ZERO)
                begin
                    next_st.flag[n] = 1'b1;
                end
                else if (st.high[n] == BYTE_TOP)
                begin
                    next_st.flag[n] = 1'b0;
                end
                else
                begin
                    next_st.flag[n] = (st.low[n] >= st.high[n]);
                end
                next_st.pinOut[n] = next_st.flag[n];
                next_st.pinOe[n]  = 1'b1;
            end
            else
            begin
                // toggle idles high and needs internal clocking
                if (!st.toggleEn[n] || st.mode[n*MODE_STRIDE+MODE_SEL])
                begin
                    next_st.toggleOut[n] = 1'b1;
                end
                else if (ovf[n])
                begin
                    next_st.toggleOut[n] = ~st.toggleOut[n];
                end
                next_st.pinOut[n] = next_st.toggleOut[n];
                next_st.pinOe[n]  = st.toggleEn[n] & ~st.mode[n*MODE_STRIDE+MODE_SEL];
            end
        end

        // read data captured in setup so the access phase answers at once
        if (setup)
        begin
            next_st.rdata = 32'h0;
            if (hit)
            begin
                unique case (idx)
                    IDX_CTRL:
                    begin
                        next_st.rdata[CTRL_RUN0]  = st.run[0];
                        next_st.rdata[CTRL_FLAG0] = st.flag[0];
                        next_st.rdata[CTRL_RUN1]  = st.run[1];
                        next_st.rdata[CTRL_FLAG1] = st.flag[1];
                    end
                    IDX_MODE:
                    begin
                        next_st.rdata[7:0] = st.mode;
                    end
                    IDX_AUX:
                    begin
                        next_st.rdata[AUX_M2_0] = st.modeHigh[0];
                        next_st.rdata[AUX_M2_1] = st.modeHigh[1];
                    end
                    IDX_LOW0:   next_st.rdata[7:0] = st.low[0];
                    IDX_HIGH0:  next_st.rdata[7:0] = st.high[0];
                    IDX_LOW1:   next_st.rdata[7:0] = st.low[1];
                    IDX_HIGH1:  next_st.rdata[7:0] = st.high[1];
                    IDX_TOGGLE: next_st.rdata[1:0] = st.toggleEn;
                    default:    next_st.rdata = 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st           <= '0;
            st.mode      <= MODE_RESET;
            st.toggleOut <= 2'h3;
            st.pinOut    <= 2'h3;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// ---- dtc_pin_model.sv ----
// Purpose: count pin source standing in for the outside world
// Assumes: pin idles high, as if pulled up
// Notes: hold sets clocks per level, 2 is the fastest legal
`timescale 1ns/1ps
module dtc_pin_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] edges,
    input  wire logic [3:0] hold,
    output logic            pin,
    output logic            busy
);
    initial
    begin
        pin = 1'b1;
        busy = 1'b0;
        forever
        begin
            @(posedge clk);
            if (go)
            begin
                busy <= 1'b1;
                repeat (edges)
                begin
                    pin <= 1'b0;
                    repeat (hold) @(posedge clk);
                    pin <= 1'b1;
                    repeat (hold) @(posedge clk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// ---- dtc_timer_asserts.sv ----
// Purpose: port checks for the timer block
// Assumes: zero-wait APB slave
// Notes: pin timing is judged by the bench
`timescale 1ns/1ps
module dtc_timer_asserts (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        countPinZeroOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_ready_high: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    chk_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    chk_mode_mapped: assert property (psel && penable && paddr == 12'h224 |-> !pslverr)
        else $error("mode register refused");
    chk_ctrl_mapped: assert property (psel && penable && paddr == 12'h220 |-> !pslverr)
        else $error("control register refused");
    chk_unaligned_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access accepted");
    chk_bad_zero: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    chk_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved without setup");
    chk_oe_by_write: assert property ($changed(countPinZeroOe)
        |-> $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
        else $error("pin enable moved without write");
endmodule
bind dtc_timer dtc_timer_asserts i_chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .countPinZeroOe);

// ---- dtc_timer_bench.sv ----
// Purpose: self-checking bench for the timer block
// Assumes: machine cycle of two clocks
// Notes: gate pin windows give exact tick counts
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin nErrors++; \
    $display("ERROR %s expected %h seen %h", n, e, a); end end
module dtc_timer_bench;
    import dtc_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [11:0] bad = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        gateZero = 1'b0;
    logic        gateOne = 1'b0;
    logic        go = 1'b0;
    logic [3:0]  holdClks = 4'h2;
    logic        countPin;
    logic        busy;
    logic        pinOut;
    logic        pinOe;
    logic        pinOutOne;
    logic        pinOeOne;
    logic        err;
    logic [7:0]  q;
    int          nErrors = 0;
    int          compares = 0;
    int          n;
    dtc_timer i_dut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .gatePinZero(gateZero), .gatePinOne(gateOne), .countPinZeroIn(countPin),
        .countPinOneIn(countPin), .countPinZeroOut(pinOut), .countPinZeroOe(pinOe),
        .countPinOneOut(pinOutOne), .countPinOneOe(pinOeOne));
    dtc_pin_model i_pins (.clk, .go, .edges(8'h05), .hold(holdClks), .pin(countPin), .busy);
    initial
    begin
        forever #20 clk = ~clk;
    end
    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, nErrors);
        if (nErrors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        paddr   <= {2'h0, idx, 2'h0} | bad;
        pwrite  <= w;
        pwdata  <= {24'h000000, d};
        psel    <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // gate held high for six edges: exactly three ticks whatever the phase
    task automatic gated_run(input logic [2:0] c, input logic [7:0] lo, hi, el, eh,
        input logic f);
        // aux first so no reserved code shows between the two writes
        apb(1'b1, IDX_AUX, {7'h00, c[2]}); // reserved codes never sent
        apb(1'b1, IDX_MODE, {4'h0, 2'h2, c[1:0]});
        apb(1'b1, IDX_CTRL, 8'h00);
        apb(1'b1, IDX_LOW0, lo);
        apb(1'b1, IDX_HIGH0, hi);
        apb(1'b1, IDX_CTRL, 8'h10);
        repeat (4) @(posedge clk);
        gateZero <= 1'b1;
        repeat (6) @(posedge clk);
        gateZero <= 1'b0;
        apb(1'b0, IDX_LOW0, 8'h00);
        `CHK("low byte", el, q)
        apb(1'b0, IDX_HIGH0, 8'h00);
        `CHK("high byte", eh, q)
        apb(1'b0, IDX_CTRL, 8'h00);
        `CHK("control", {2'h0, f, 5'h10}, q)
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        nErrors++;
        end_of_test();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(1'b0, IDX_MODE, 8'h00);
        `CHK("mode reset", MODE_RESET, q)
        apb(1'b0, IDX_CTRL, 8'h00);
        `CHK("ctrl reset", 8'h00, q)
        apb(1'b1, IDX_MODE, 8'h22);
        apb(1'b1, IDX_AUX, 8'hff);
        apb(1'b0, IDX_AUX, 8'h00);
        `CHK("aux bits", 8'h11, q)
        apb(1'b1, IDX_MODE, 8'h6a);
        bad = 12'h001;
        apb(1'b1, IDX_MODE, 8'hff);
        `CHK("misaligned err", 1'b1, err)
        bad = 12'h800;
        apb(1'b0, IDX_MODE, 8'h00);
        `CHK("far read", 8'h00, q)
        `CHK("far err", 1'b1, err)
        bad = 12'h000;
        apb(1'b0, IDX_MODE, 8'h00);
        `CHK("mode kept", 8'h6a, q)
        `CHK("mapped err", 1'b0, err)
        apb(1'b0, 8'h95, 8'h00);
        `CHK("unmapped", 8'h00, q)
        `CHK("unmapped err", 1'b1, err)
        gated_run(CODE_WIDE, 8'hfe, 8'hff, 8'h01, 8'h00, 1'b1);
        gated_run(CODE_PRESC, 8'hfe, 8'hff, 8'he1, 8'h00, 1'b1);
        gated_run(CODE_RELOAD, 8'hfe, 8'h80, 8'h81, 8'h80, 1'b1);
        gated_run(CODE_SPLIT, 8'hfe, 8'hff, 8'h01, 8'hff, 1'b1);
        // split high byte runs on timer one run bit and owns its flag
        apb(1'b1, IDX_CTRL, 8'h40);
        repeat (4) @(posedge clk);
        apb(1'b0, IDX_CTRL, 8'h00);
        `CHK("split high flag", 8'hc0, q)
        // timer zero counts pin edges, timer one parked in split code
        apb(1'b1, IDX_AUX, 8'h00);
        apb(1'b1, IDX_MODE, 8'h35);
        apb(1'b1, IDX_LOW0, 8'h00);
        apb(1'b1, IDX_LOW1, 8'h40);
        apb(1'b1, IDX_CTRL, 8'h50);
        for (int h = 2; h < 4; h++)
        begin
            holdClks <= h[3:0];
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            @(posedge clk);
            while (busy !== 1'b0)
                @(posedge clk);
        end
        repeat (6) @(posedge clk);
        apb(1'b0, IDX_LOW0, 8'h00);
        `CHK("edge count", 8'h0a, q)
        apb(1'b0, IDX_LOW1, 8'h00);
        `CHK("timer one held", 8'h40, q)
        apb(1'b1, IDX_CTRL, 8'h00);
        apb(1'b1, IDX_MODE, 8'h02);
        apb(1'b1, IDX_LOW0, 8'hfc);
        apb(1'b1, IDX_HIGH0, 8'hfc);
        apb(1'b1, IDX_TOGGLE, 8'h01);
        repeat (3) @(posedge clk);
        `CHK("pin enable", 1'b1, pinOe)
        `CHK("pin start", 1'b1, pinOut)
        apb(1'b1, IDX_CTRL, 8'h10);
        // pins looked at on the falling edge, clear of the launching edge
        while (pinOut !== 1'b0)
            @(negedge clk);
        n = 0;
        while (pinOut === 1'b0)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("toggle period", 8, n)
        @(posedge clk);
        // timer one as PWM, held by its gate pin until released
        apb(1'b1, IDX_CTRL, 8'h00);
        apb(1'b1, IDX_MODE, 8'ha0);
        apb(1'b1, IDX_AUX, 8'h10);
        apb(1'b1, IDX_LOW1, 8'h00);
        apb(1'b1, IDX_HIGH1, 8'h03);
        apb(1'b1, IDX_CTRL, 8'h40);
        repeat (6) @(posedge clk);
        apb(1'b0, IDX_LOW1, 8'h00);
        `CHK("gate one hold", 8'h00, q)
        `CHK("pwm enable", 1'b1, pinOeOne)
        `CHK("pwm start low", 1'b0, pinOutOne)
        gateOne <= 1'b1;
        @(negedge clk);
        while (pinOutOne !== 1'b1)
            @(negedge clk);
        while (pinOutOne !== 1'b0)
            @(negedge clk);
        n = 0;
        while (pinOutOne === 1'b0)
        begin
            @(negedge clk);
            n++;
        end
        `CHK("pwm low time", 6, n)
        end_of_test();
    end
endmodule
